/* cca_regs.svh */
// Addresses, field positions and reset values of the counter array registers.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH

`define CCA_NUM_CH         6
`define CCA_BYTE_RESET     8'h00
`define CCA_WORD_RESET     16'h0000

`define CCA_COUNTER_LOW    8'hf9
`define CCA_COUNTER_HIGH   8'hfa

`define CCA_CAPTURE_LOW_M0  8'hfb
`define CCA_CAPTURE_HIGH_M0 8'hfc
`define CCA_CAPTURE_LOW_M1  8'he9
`define CCA_CAPTURE_HIGH_M1 8'hea
`define CCA_CAPTURE_LOW_M2  8'heb
`define CCA_CAPTURE_HIGH_M2 8'hec
`define CCA_CAPTURE_LOW_M3  8'hed
`define CCA_CAPTURE_HIGH_M3 8'hee
`define CCA_CAPTURE_LOW_M4  8'hfd
`define CCA_CAPTURE_HIGH_M4 8'hfe
`define CCA_CAPTURE_LOW_M5  8'hce
`define CCA_CAPTURE_HIGH_M5 8'hcf

`define CCA_MODE_M0        8'hda
`define CCA_MODE_M1        8'hdb
`define CCA_MODE_M2        8'hdc
`define CCA_MODE_M3        8'hdd
`define CCA_MODE_M4        8'hde
`define CCA_MODE_M5        8'hdf

`define CCA_MODE_WIDE_PWM  7
`define CCA_MODE_CMP_EN    6

`define CCA_WATCHDOG_CH    5

`endif

/* cca_pkg.sv */
// Types shared by the counter array register logic.
// Assumes nothing beyond the constants header.
`include "cca_regs.svh"

package cca_pkg;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cca_sfr_s;

   typedef struct packed {
      logic [15:0] cmp;
      logic [15:0] reload;
      logic [7:0]  mode;
   } cca_chan_state_s;

   typedef struct packed {
      logic [15:0] counter;
      logic [7:0]  snapshot;
      logic [7:0]  rdata;
   } cca_top_state_s;

endpackage

/* cca_channel.sv */
// One capture/compare module: compare value, auto-reload value and mode byte.
// Assumes a single-cycle special-function-register request on mclk.
`timescale 1ns/100ps
`include "cca_regs.svh"

module cca_channel #(
   parameter logic [7:0] LOW_ADDR  = `CCA_CAPTURE_LOW_M0,
   parameter logic [7:0] HIGH_ADDR = `CCA_CAPTURE_HIGH_M0,
   parameter logic [7:0] MODE_ADDR = `CCA_MODE_M0,
   parameter bit         LOCKABLE  = 1'b0
) (
   input  wire logic              mclk,
   input  wire logic              srst,
   input  wire cca_pkg::cca_sfr_s bus,
   input  wire logic              auto_reload_select,
   input  wire logic              watchdog_enable,
   output logic                   rd_hit,
   output logic [7:0]             rd_data,
   output logic [15:0]            capture_compare_value,
   output logic [15:0]            reload_value,
   output logic [7:0]             mode
);
   import cca_pkg::*;

   cca_chan_state_s st;
   cca_chan_state_s next_st;
   logic            low_wr;
   logic            high_wr;
   logic            mode_wr;

   assign low_wr  = bus.wr && (bus.addr == LOW_ADDR);
   assign high_wr = bus.wr && (bus.addr == HIGH_ADDR);
   assign mode_wr = bus.wr && (bus.addr == MODE_ADDR);

   always_comb begin
      next_st = st;
      if (low_wr) begin
         if (auto_reload_select) begin
            next_st.reload[7:0] = bus.wdata;
         end else begin
            next_st.cmp[7:0] = bus.wdata;
            next_st.mode[`CCA_MODE_CMP_EN] = 1'b0;
         end
      end
      if (high_wr) begin
         if (auto_reload_select) begin
            next_st.reload[15:8] = bus.wdata;
         end else begin
            next_st.cmp[15:8] = bus.wdata;
            next_st.mode[`CCA_MODE_CMP_EN] = 1'b1;
         end
      end
      // The watchdog channel ignores mode byte writes while the watchdog runs; compare byte writes still move bit 6.
      if (mode_wr && !(LOCKABLE && watchdog_enable)) begin
         next_st.mode = bus.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '{cmp: `CCA_WORD_RESET, reload: `CCA_WORD_RESET, mode: `CCA_BYTE_RESET};
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      rd_hit  = bus.rd && (bus.addr == LOW_ADDR || bus.addr == HIGH_ADDR
                           || bus.addr == MODE_ADDR);
      rd_data = `CCA_BYTE_RESET;
      if (bus.rd && bus.addr == LOW_ADDR) begin
         rd_data = auto_reload_select ? st.reload[7:0] : st.cmp[7:0];
      end else if (bus.rd && bus.addr == HIGH_ADDR) begin
         rd_data = auto_reload_select ? st.reload[15:8] : st.cmp[15:8];
      end else if (bus.rd && bus.addr == MODE_ADDR) begin
         rd_data = st.mode;
      end
   end

   assign capture_compare_value = st.cmp;
   assign reload_value          = st.reload;
   assign mode                  = st.mode;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   low_write_clear_a: assert property (
      low_wr && !auto_reload_select |=> !st.mode[`CCA_MODE_CMP_EN]
                                        && st.cmp[7:0] == $past(bus.wdata))
      else $error("Low compare byte write did not clear the enable.");

   high_write_set_a: assert property (
      high_wr && !auto_reload_select |=> st.mode[`CCA_MODE_CMP_EN]
                                         && st.cmp[15:8] == $past(bus.wdata))
      else $error("High compare byte write did not set the enable.");

   reload_write_a: assert property (
      low_wr && auto_reload_select |=> st.reload[7:0] == $past(bus.wdata)
                                       && $stable(st.cmp) && $stable(st.mode))
      else $error("Reload low write touched the compare path.");

   reset_zero_a: assert property (@(posedge mclk)
      $past(srst) |-> st.cmp == `CCA_WORD_RESET)
      else $error("Compare value not zero after reset.");

   rearm_seen_c: cover property (
      low_wr && !auto_reload_select ##[1:8] high_wr && !auto_reload_select);
endmodule

/* cca_counter_regs.sv */
// Register logic of a 16-bit counter array with six capture/compare modules.
// Assumes the core's special-function-register bus on mclk: one request per
// cycle, read data registered and valid in the cycle after the read strobe.
`timescale 1ns/100ps
`include "cca_regs.svh"

// What this block does
// - A counter high byte read returns a snapshot that only a low byte read refreshes.
// - Counter high byte writes are dropped while the watchdog is enabled.
// - Each of six modules holds a 16-bit compare value in two bytes, reset to zero.
// - With auto-reload select set, the module low byte address reaches the reload low byte.
// - With auto-reload select set, the module high byte address reaches the reload high byte.
// - A write to a module low compare byte clears its comparator enable.
// - A write to a module high compare byte sets its comparator enable.
// - Counter low byte writes are dropped while the watchdog is enabled.
// - Mode bit 6 is the comparator enable of its module.
// - Mode bit 7 picks 16-bit PWM when 1 and 8 to 11-bit PWM when 0.
module cca_counter_regs (
   input  wire logic              mclk,
   input  wire logic              srst,
   input  wire cca_pkg::cca_sfr_s sfr,
   input  wire logic              count_run,
   input  wire logic              auto_reload_select,
   input  wire logic              watchdog_enable,
   output logic [7:0]             sfr_rdata,
   output logic [15:0]            counter_value,
   output logic [7:0]             counter_snapshot,
   output logic [5:0]             comparator_enable,
   output logic [5:0]             wide_pwm_select,
   output logic [95:0]            capture_compare_values,
   output logic [95:0]            reload_values
);
   import cca_pkg::*;

   localparam int NCH = `CCA_NUM_CH;

   localparam logic [7:0] LOW_ADDRS [NCH] = '{
      `CCA_CAPTURE_LOW_M0, `CCA_CAPTURE_LOW_M1, `CCA_CAPTURE_LOW_M2,
      `CCA_CAPTURE_LOW_M3, `CCA_CAPTURE_LOW_M4, `CCA_CAPTURE_LOW_M5
   };
   localparam logic [7:0] HIGH_ADDRS [NCH] = '{
      `CCA_CAPTURE_HIGH_M0, `CCA_CAPTURE_HIGH_M1, `CCA_CAPTURE_HIGH_M2,
      `CCA_CAPTURE_HIGH_M3, `CCA_CAPTURE_HIGH_M4, `CCA_CAPTURE_HIGH_M5
   };
   localparam logic [7:0] MODE_ADDRS [NCH] = '{
      `CCA_MODE_M0, `CCA_MODE_M1, `CCA_MODE_M2,
      `CCA_MODE_M3, `CCA_MODE_M4, `CCA_MODE_M5
   };

   cca_top_state_s st;
   cca_top_state_s next_st;

   logic [NCH-1:0] ch_hit;
   logic [7:0]     ch_data [NCH];
   logic [7:0]     ch_mode [NCH];
   logic           low_rd;
   logic           high_rd;
   logic           low_wr;
   logic           high_wr;
   logic           any_ch_hit;
   logic [7:0]     ch_rdata;

   assign low_rd  = sfr.rd && (sfr.addr == `CCA_COUNTER_LOW);
   assign high_rd = sfr.rd && (sfr.addr == `CCA_COUNTER_HIGH);
   assign low_wr  = sfr.wr && (sfr.addr == `CCA_COUNTER_LOW);
   assign high_wr = sfr.wr && (sfr.addr == `CCA_COUNTER_HIGH);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         cca_channel #(
            .LOW_ADDR  (LOW_ADDRS[g]),
            .HIGH_ADDR (HIGH_ADDRS[g]),
            .MODE_ADDR (MODE_ADDRS[g]),
            .LOCKABLE  (g == `CCA_WATCHDOG_CH)
         ) u_ch (
            .mclk                  (mclk),
            .srst                  (srst),
            .bus                   (sfr),
            .auto_reload_select    (auto_reload_select),
            .watchdog_enable       (watchdog_enable),
            .rd_hit                (ch_hit[g]),
            .rd_data               (ch_data[g]),
            .capture_compare_value (capture_compare_values[16*g +: 16]),
            .reload_value          (reload_values[16*g +: 16]),
            .mode                  (ch_mode[g])
         );
         assign comparator_enable[g] = ch_mode[g][`CCA_MODE_CMP_EN];
         assign wide_pwm_select[g]   = ch_mode[g][`CCA_MODE_WIDE_PWM];
      end
   endgenerate

   // Only one channel can claim an address, so an OR of the gated bytes is a mux.
   always_comb begin
      ch_rdata   = `CCA_BYTE_RESET;
      any_ch_hit = |ch_hit;
      for (int i = 0; i < NCH; i++) begin
         ch_rdata = ch_rdata | ch_data[i];
      end
   end

   always_comb begin
      next_st = st;
      if (count_run) begin
         next_st.counter = st.counter + 16'h0001;
      end
      // A software write replaces its byte of the count, but never while the watchdog runs.
      if (low_wr && !watchdog_enable) begin
         next_st.counter[7:0] = sfr.wdata;
      end
      if (high_wr && !watchdog_enable) begin
         next_st.counter[15:8] = sfr.wdata;
      end
      if (low_rd) begin
         next_st.snapshot = st.counter[15:8];
      end
      if (low_rd) begin
         next_st.rdata = st.counter[7:0];
      end else if (high_rd) begin
         next_st.rdata = st.snapshot;
      end else if (any_ch_hit) begin
         next_st.rdata = ch_rdata;
      end else begin
         next_st.rdata = `CCA_BYTE_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '{counter: `CCA_WORD_RESET, snapshot: `CCA_BYTE_RESET,
                 rdata: `CCA_BYTE_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata        = st.rdata;
   assign counter_value    = st.counter;
   assign counter_snapshot = st.snapshot;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   snapshot_on_low_a: assert property (
      low_rd |=> st.snapshot == $past(st.counter[15:8]))
      else $error("Snapshot did not take the high byte at the low read.");

   snapshot_holds_a: assert property (
      !low_rd && !srst |=> $stable(st.snapshot))
      else $error("Snapshot changed without a low byte read.");

   high_reads_snap_a: assert property (
      high_rd |=> sfr_rdata == $past(st.snapshot))
      else $error("High byte read did not return the snapshot.");

   coherent_pair_a: assert property (
      low_rd ##1 high_rd |=> sfr_rdata == $past(st.counter[15:8], 2))
      else $error("Low then high read did not form one sample.");

   wd_high_lock_a: assert property (
      high_wr && watchdog_enable && !count_run |=> $stable(st.counter))
      else $error("Counter high byte written while the watchdog ran.");

   wd_low_lock_a: assert property (
      low_wr && watchdog_enable |=>
         st.counter == $past(st.counter) + 16'($past(count_run)))
      else $error("Counter low byte written while the watchdog ran.");

   high_write_a: assert property (
      high_wr && !watchdog_enable |=> st.counter[15:8] == $past(sfr.wdata))
      else $error("Counter high byte write was lost.");

   mode_bits_a: assert property (
      sfr.wr && sfr.addr == `CCA_MODE_M0 |=>
         comparator_enable[0] == $past(sfr.wdata[`CCA_MODE_CMP_EN])
         && wide_pwm_select[0] == $past(sfr.wdata[`CCA_MODE_WIDE_PWM]))
      else $error("Mode bits did not follow the mode write.");

   wd_mode_lock_a: assert property (
      sfr.wr && sfr.addr == `CCA_MODE_M5 && watchdog_enable
      |=> $stable(ch_mode[`CCA_WATCHDOG_CH]))
      else $error("Watchdog channel mode changed while locked.");

   arm_m0_a: assert property (
      sfr.wr && sfr.addr == `CCA_CAPTURE_HIGH_M0 && !auto_reload_select
      |=> comparator_enable[0])
      else $error("Module 0 high write did not arm the compare.");

   disarm_m0_a: assert property (
      sfr.wr && sfr.addr == `CCA_CAPTURE_LOW_M0 && !auto_reload_select
      |=> !comparator_enable[0])
      else $error("Module 0 low write did not disarm the compare.");

   reload_read_a: assert property (
      sfr.rd && sfr.addr == `CCA_CAPTURE_HIGH_M1 && auto_reload_select
      |=> sfr_rdata == $past(reload_values[31:24]))
      else $error("Reload high byte read returned the wrong value.");

   compare_read_a: assert property (
      sfr.rd && sfr.addr == `CCA_CAPTURE_LOW_M1 && !auto_reload_select
      |=> sfr_rdata == $past(capture_compare_values[23:16]))
      else $error("Compare low byte read returned the wrong value.");

   unmapped_zero_a: assert property (
      sfr.rd && !low_rd && !high_rd && !any_ch_hit |=> sfr_rdata == 8'h00)
      else $error("Unmapped read did not return zero.");

   low_write_a: assert property (
      low_wr && !watchdog_enable |=> st.counter[7:0] == $past(sfr.wdata))
      else $error("Counter low byte write was lost.");

   wd_high_count_a: assert property (
      high_wr && watchdog_enable |=>
         st.counter == $past(st.counter) + 16'($past(count_run)))
      else $error("Locked counter high write changed the count.");

   low_read_data_a: assert property (
      low_rd |=> sfr_rdata == $past(st.counter[7:0]))
      else $error("Counter low byte read returned the wrong value.");

   // Read data stands for one cycle only and then falls back to zero.
   rdata_stands_a: assert property (
      !sfr.rd |=> sfr_rdata == 8'h00)
      else $error("Read data outlived its read cycle.");

   count_step_a: assert property (
      count_run && !low_wr && !high_wr && !srst |=>
         st.counter == $past(st.counter) + 16'h0001)
      else $error("Counter did not advance by one.");

   reset_outputs_a: assert property (
      $past(srst) |-> capture_compare_values == 96'h0 && reload_values == 96'h0
                      && comparator_enable == 6'h00)
      else $error("Module values not zero after reset.");

   // The same byte-level checks for every module, seen from the top outputs.
   for (genvar k = 0; k < NCH; k++) begin : gen_chk
      disarm_each_a: assert property (
         sfr.wr && sfr.addr == LOW_ADDRS[k] && !auto_reload_select |=>
            !comparator_enable[k]
            && capture_compare_values[16*k +: 8] == $past(sfr.wdata))
         else $error("Module low compare write did not disarm it.");

      arm_each_a: assert property (
         sfr.wr && sfr.addr == HIGH_ADDRS[k] && !auto_reload_select |=>
            comparator_enable[k]
            && capture_compare_values[16*k+8 +: 8] == $past(sfr.wdata))
         else $error("Module high compare write did not arm it.");

      reload_low_each_a: assert property (
         sfr.wr && sfr.addr == LOW_ADDRS[k] && auto_reload_select |=>
            reload_values[16*k +: 8] == $past(sfr.wdata)
            && $stable(capture_compare_values[16*k +: 16]))
         else $error("Module reload low write went astray.");

      reload_high_each_a: assert property (
         sfr.wr && sfr.addr == HIGH_ADDRS[k] && auto_reload_select |=>
            reload_values[16*k+8 +: 8] == $past(sfr.wdata)
            && $stable(capture_compare_values[16*k +: 16]))
         else $error("Module reload high write went astray.");

      reload_lo_rd_a: assert property (
         sfr.rd && sfr.addr == LOW_ADDRS[k] && auto_reload_select |=>
            sfr_rdata == $past(reload_values[16*k +: 8]))
         else $error("Module reload low read returned the wrong value.");

      cmp_lo_rd_a: assert property (
         sfr.rd && sfr.addr == LOW_ADDRS[k] && !auto_reload_select |=>
            sfr_rdata == $past(capture_compare_values[16*k +: 8]))
         else $error("Module compare low read returned the wrong value.");

      reload_hi_rd_a: assert property (
         sfr.rd && sfr.addr == HIGH_ADDRS[k] && auto_reload_select |=>
            sfr_rdata == $past(reload_values[16*k+8 +: 8]))
         else $error("Module reload high read returned the wrong value.");

      cmp_hi_rd_a: assert property (
         sfr.rd && sfr.addr == HIGH_ADDRS[k] && !auto_reload_select |=>
            sfr_rdata == $past(capture_compare_values[16*k+8 +: 8]))
         else $error("Module compare high read returned the wrong value.");

      mode_rd_each_a: assert property (
         sfr.rd && sfr.addr == MODE_ADDRS[k] |=>
            sfr_rdata[`CCA_MODE_CMP_EN] == $past(comparator_enable[k]))
         else $error("Module mode read did not show the comparator enable.");

      wide_each_a: assert property (
         sfr.wr && sfr.addr == MODE_ADDRS[k]
         && (k != `CCA_WATCHDOG_CH || !watchdog_enable) |=>
            wide_pwm_select[k] == $past(sfr.wdata[`CCA_MODE_WIDE_PWM]))
         else $error("Module wide PWM select did not follow the mode write.");
   end

   pair_read_c: cover property (low_rd ##1 high_rd);

   wd_block_c: cover property (high_wr && watchdog_enable);

   reload_path_c: cover property (
      sfr.wr && sfr.addr == `CCA_CAPTURE_LOW_M2 && auto_reload_select);

   rearm_m0_c: cover property (
      sfr.wr && sfr.addr == `CCA_CAPTURE_LOW_M0 ##[1:4]
      sfr.wr && sfr.addr == `CCA_CAPTURE_HIGH_M0 ##1 comparator_enable[0]);
endmodule

/* cca_counter_regs_tb.sv */
// Self-checking bench for the counter array register logic.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/100ps
`include "cca_regs.svh"

module cca_counter_regs_tb;
   import cca_pkg::*;

   localparam int LIMIT = 6000;

   logic            mclk;
   logic            srst;
   cca_sfr_s        sfr;
   logic            count_run;
   logic            auto_reload_select;
   logic            watchdog_enable;
   logic [7:0]      sfr_rdata;
   logic [15:0]     counter_value;
   logic [7:0]      counter_snapshot;
   logic [5:0]      comparator_enable;
   logic [5:0]      wide_pwm_select;
   logic [95:0]     capture_compare_values;
   logic [95:0]     reload_values;
   int              errors;
   int              checked;
   int              cycles;
   logic [7:0]      lo_addr [6];
   logic [7:0]      hi_addr [6];
   logic [7:0]      mode_addr [6];

   cca_counter_regs uut (
      .mclk                   (mclk),
      .srst                   (srst),
      .sfr                    (sfr),
      .count_run              (count_run),
      .auto_reload_select     (auto_reload_select),
      .watchdog_enable        (watchdog_enable),
      .sfr_rdata              (sfr_rdata),
      .counter_value          (counter_value),
      .counter_snapshot       (counter_snapshot),
      .comparator_enable      (comparator_enable),
      .wide_pwm_select        (wide_pwm_select),
      .capture_compare_values (capture_compare_values),
      .reload_values          (reload_values)
   );

   initial begin
      mclk = 1'b0;
   end

   always #50 mclk = ~mclk;

   task automatic conclude();
      $display("mismatches %0d of %0d comparisons", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // The run is cut short here if a test never returns.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors = errors + 1;
         conclude();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Each request is one cycle wide; outputs are sampled after the taking edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr <= '{1'b0, 1'b1, a, d};
      @(posedge mclk);
      sfr <= '{1'b0, 1'b0, 8'h00, 8'h00};
      #10;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      sfr <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge mclk);
      sfr <= '{1'b0, 1'b0, 8'h00, 8'h00};
      #10;
      chk({8'h00, sfr_rdata}, {8'h00, exp});
   endtask

   // Counter low then high read on consecutive cycles.
   task automatic rd_pair(input logic [7:0] exp_lo, input logic [7:0] exp_hi);
      @(posedge mclk);
      sfr <= '{1'b1, 1'b0, `CCA_COUNTER_LOW, 8'h00};
      @(posedge mclk);
      sfr <= '{1'b1, 1'b0, `CCA_COUNTER_HIGH, 8'h00};
      #10;
      chk({8'h00, sfr_rdata}, {8'h00, exp_lo});
      @(posedge mclk);
      sfr <= '{1'b0, 1'b0, 8'h00, 8'h00};
      #10;
      chk({8'h00, sfr_rdata}, {8'h00, exp_hi});
   endtask

   initial begin
      errors = 0;
      checked = 0;
      cycles = 0;
      srst = 1'b1;
      sfr = '{1'b0, 1'b0, 8'h00, 8'h00};
      count_run = 1'b0;
      auto_reload_select = 1'b0;
      watchdog_enable = 1'b0;
      lo_addr = '{`CCA_CAPTURE_LOW_M0, `CCA_CAPTURE_LOW_M1, `CCA_CAPTURE_LOW_M2,
                  `CCA_CAPTURE_LOW_M3, `CCA_CAPTURE_LOW_M4, `CCA_CAPTURE_LOW_M5};
      hi_addr = '{`CCA_CAPTURE_HIGH_M0, `CCA_CAPTURE_HIGH_M1, `CCA_CAPTURE_HIGH_M2,
                  `CCA_CAPTURE_HIGH_M3, `CCA_CAPTURE_HIGH_M4, `CCA_CAPTURE_HIGH_M5};
      mode_addr = '{`CCA_MODE_M0, `CCA_MODE_M1, `CCA_MODE_M2,
                    `CCA_MODE_M3, `CCA_MODE_M4, `CCA_MODE_M5};
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      for (int n = 0; n < 6; n++) begin
         rd(lo_addr[n], 8'h00);
         rd(hi_addr[n], 8'h00);
      end
      rd(8'h00, 8'h00);
      for (int n = 0; n < 6; n++) begin
         wr(mode_addr[n], 8'h40);
         chk(comparator_enable[n], 1'b1);
         wr(lo_addr[n], 8'h11 + n[7:0]);
         chk(comparator_enable[n], 1'b0);
         wr(hi_addr[n], 8'ha0 + n[7:0]);
         chk(comparator_enable[n], 1'b1);
         chk(capture_compare_values[16*n +: 16], {8'ha0 + n[7:0], 8'h11 + n[7:0]});
         rd(lo_addr[n], 8'h11 + n[7:0]);
         rd(hi_addr[n], 8'ha0 + n[7:0]);
         @(posedge mclk);
         auto_reload_select <= 1'b1;
         wr(lo_addr[n], 8'h50 + n[7:0]);
         wr(hi_addr[n], 8'h0c + n[7:0]);
         chk(reload_values[16*n +: 16], {8'h0c + n[7:0], 8'h50 + n[7:0]});
         chk(capture_compare_values[16*n +: 16], {8'ha0 + n[7:0], 8'h11 + n[7:0]});
         rd(lo_addr[n], 8'h50 + n[7:0]);
         rd(hi_addr[n], 8'h0c + n[7:0]);
         @(posedge mclk);
         auto_reload_select <= 1'b0;
         rd(lo_addr[n], 8'h11 + n[7:0]);
         wr(mode_addr[n], 8'h80);
         chk({wide_pwm_select[n], comparator_enable[n]}, 2'b10);
         rd(mode_addr[n], 8'h80);
      end
      // Counter contents are set while the count is held still.
      wr(`CCA_COUNTER_LOW, 8'hff);
      wr(`CCA_COUNTER_HIGH, 8'h12);
      chk(counter_value, 16'h12ff);
      rd(`CCA_COUNTER_LOW, 8'hff);
      chk(counter_snapshot, 8'h12);
      @(posedge mclk);
      count_run <= 1'b1;
      repeat (5) @(posedge mclk);
      count_run <= 1'b0;
      #10;
      chk(counter_value, 16'h1304);
      rd(`CCA_COUNTER_HIGH, 8'h12);
      rd(`CCA_COUNTER_LOW, 8'h04);
      rd(`CCA_COUNTER_HIGH, 8'h13);
      @(posedge mclk);
      watchdog_enable <= 1'b1;
      wr(`CCA_COUNTER_LOW, 8'h5a);
      chk(counter_value, 16'h1304);
      wr(`CCA_COUNTER_HIGH, 8'ha5);
      chk(counter_value, 16'h1304);
      wr(`CCA_MODE_M5, 8'h40);
      chk({wide_pwm_select[5], comparator_enable[5]}, 2'b10);
      @(posedge mclk);
      watchdog_enable <= 1'b0;
      wr(`CCA_COUNTER_HIGH, 8'ha5);
      chk(counter_value, 16'ha504);
      wr(`CCA_COUNTER_LOW, 8'h5a);
      chk(counter_value, 16'ha55a);
      rd_pair(8'h5a, 8'ha5);
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      #10;
      chk(capture_compare_values[15:0], 16'h0000);
      chk(counter_value, 16'h0000);
      conclude();
   end
endmodule
